// *** common/sbo_pkg.sv ***
package sbo_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX_ED    = 8'hED;
  localparam logic [7:0] OP_OUT_INC      = 8'hA3;
  localparam logic [7:0] OP_PREFIX_IDX1  = 8'hDD;
  localparam logic [7:0] OP_PREFIX_IDX2  = 8'hFD;
  localparam logic [7:0] OP_POP_IDX      = 8'hE1;
  localparam logic [7:0] OP_PAIR_MASK    = 8'hCF;
  localparam logic [7:0] OP_POP_PAIR     = 8'hC1;
  localparam logic [7:0] OP_PUSH_PAIR    = 8'hC5;
  localparam int         PAIR_FIELD_LSB  = 4;

  // ---------------------------------------------------------------
  // register pair field and flag positions
  // ---------------------------------------------------------------
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_AF = 2'h3;
  localparam int         FLAG_Z  = 6;
  localparam int         FLAG_N  = 1;

  localparam logic [15:0] WORD_ONE  = 16'h0001;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] hl;
    logic [15:0] af;
    logic [15:0] first_index_reg;
    logic [15:0] second_index_reg;
    logic [15:0] stack_pointer;
  } sbo_regs_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sbo_bus_t;

  typedef enum logic [3:0] {
    ST_FETCH1, ST_FETCH2, ST_OI_RD, ST_OI_WR,
    ST_POP_LO, ST_POP_HI, ST_PUSH_HI, ST_PUSH_LO
  } sbo_state_t;

  typedef enum logic [1:0] {
    DST_PAIR, DST_IDX1, DST_IDX2
  } sbo_dst_t;

endpackage : sbo_pkg

// *** core/sbo_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbo_decode (
  input  wire logic [7:0] i_prefix,
  input  wire logic [7:0] i_op,
  output logic            o_out_inc,
  output logic            o_pop_idx1,
  output logic            o_pop_idx2,
  output logic            o_pop_pair,
  output logic            o_push_pair,
  output logic [1:0]      o_pair
);
  import sbo_pkg::*;

  always_comb begin
    o_out_inc   = (i_prefix == OP_PREFIX_ED) && (i_op == OP_OUT_INC);
    o_pop_idx1  = (i_prefix == OP_PREFIX_IDX1) && (i_op == OP_POP_IDX);
    o_pop_idx2  = (i_prefix == OP_PREFIX_IDX2) && (i_op == OP_POP_IDX);
    o_pop_pair  = ((i_op & OP_PAIR_MASK) == OP_POP_PAIR);
    o_push_pair = ((i_op & OP_PAIR_MASK) == OP_PUSH_PAIR);
    o_pair      = i_op[PAIR_FIELD_LSB +: 2];
  end
endmodule : sbo_decode
`default_nettype wire

// *** core/sbo_pair_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbo_pair_sel (
  input  wire logic             [1:0] i_pair,
  input  wire sbo_pkg::sbo_regs_t     i_regs,
  output logic                 [15:0] o_value
);
  import sbo_pkg::*;

  always_comb begin
    if (i_pair == PAIR_BC) begin
      o_value = i_regs.bc;
    end else if (i_pair == PAIR_DE) begin
      o_value = i_regs.de;
    end else if (i_pair == PAIR_HL) begin
      o_value = i_regs.hl;
    end else begin
      o_value = i_regs.af;
    end
  end
endmodule : sbo_pair_sel
`default_nettype wire

// *** core/sbo_core.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - output-and-increment first reads the byte at the memory pointer pair and holds it.
// - the byte counter is decremented and driven on the upper address byte, port select low.
// - the port select byte is the low byte of the 16-bit I/O port address; the counter is the high byte.
// - the held byte is then written to that port, after which the memory pointer increments.
// - output-and-increment decodes as the two bytes ED then A3.
// - it sets zero when the new counter is zero, sets subtract, and keeps the other flags.
// - a pair pop reads low byte at the stack pointer, increments, reads high, increments.
// - the pair field picks BC, DE, HL or the accumulator/flag pair for 00, 01, 10, 11.
// - a pair pop keeps flags unless the pair is the accumulator/flag pair.
// - pops never check underflow; the stack pointer just wraps upward.
// - first index pop is DD E1 with the low-then-high read and two increments.
// - second index pop is FD E1 with the same sequence.
// - index pops leave every flag unchanged.
// - a pair push decrements, writes high byte, decrements, writes low byte.
// - pushes never check overflow; the stack pointer just wraps downward.
// - pair push is the single byte 11qq0101 and alters no flag.
module sbo_core (
  input  wire logic                I_MCLK,
  input  wire logic                I_RST,
  input  wire logic                I_BUS_ACK,
  input  wire logic [7:0]          I_BUS_RDATA,
  input  wire sbo_pkg::sbo_regs_t  I_LOAD_REGS,
  input  wire logic                I_LOAD,
  output var sbo_pkg::sbo_bus_t    O_BUS,
  output var sbo_pkg::sbo_regs_t   O_REGS,
  output logic                     O_IDLE,
  output logic                     O_ILLEGAL
);
  import sbo_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sbo_state_t  state;
    sbo_regs_t   regs;
    sbo_bus_t    bus;
    logic [7:0]  prefix;
    logic [7:0]  op;
    logic [7:0]  held;
    logic [7:0]  lo;
    sbo_dst_t    dst;
    logic [1:0]  pair;
    logic        illegal;
  } sbo_core_t;

  sbo_core_t st_reg;
  sbo_core_t st_next;

  logic        dec_out_inc;
  logic        dec_pop_idx1;
  logic        dec_pop_idx2;
  logic        dec_pop_pair;
  logic        dec_push_pair;
  logic [1:0]  dec_pair;
  logic [15:0] push_value;
  logic [7:0]  fetched;
  logic [7:0]  count_dec;

  assign fetched = I_BUS_RDATA;

  sbo_decode u_decode (
    .i_prefix    (st_reg.prefix),
    .i_op        (fetched),
    .o_out_inc   (dec_out_inc),
    .o_pop_idx1  (dec_pop_idx1),
    .o_pop_idx2  (dec_pop_idx2),
    .o_pop_pair  (dec_pop_pair),
    .o_push_pair (dec_push_pair),
    .o_pair      (dec_pair)
  );

  sbo_pair_sel u_pair_sel (
    .i_pair  (st_reg.pair),
    .i_regs  (st_reg.regs),
    .o_value (push_value)
  );

  assign count_dec = st_reg.regs.bc[15:8] - BYTE_ONE;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // bus request is held until acknowledged; one byte per acknowledge
  function automatic sbo_bus_t mem_rd(input logic [15:0] a);
    sbo_bus_t b;
    b       = '0;
    b.req   = 1'b1;
    b.addr  = a;
    return b;
  endfunction : mem_rd

  always_comb begin
    st_next = st_reg;
    if (I_LOAD && st_reg.state == ST_FETCH1) begin
      st_next.regs = I_LOAD_REGS;
    end
    case (st_reg.state)
      ST_FETCH1: begin
        st_next.bus = mem_rd(st_next.regs.stack_pointer);
        st_next.bus.req = 1'b0;
        st_next.prefix = BYTE_ZERO;
        // instruction bytes arrive with acknowledge; fetch address is the caller's
        if (I_BUS_ACK) begin
          st_next.illegal = 1'b0;
          if (fetched == OP_PREFIX_ED || fetched == OP_PREFIX_IDX1
              || fetched == OP_PREFIX_IDX2) begin
            st_next.prefix = fetched;
            st_next.state  = ST_FETCH2;
          end else if (dec_pop_pair) begin
            st_next.dst   = DST_PAIR;
            st_next.pair  = dec_pair;
            st_next.bus   = mem_rd(st_reg.regs.stack_pointer);
            st_next.state = ST_POP_LO;
          end else if (dec_push_pair) begin
            st_next.pair  = dec_pair;
            st_next.regs.stack_pointer = st_reg.regs.stack_pointer - WORD_ONE;
            st_next.state = ST_PUSH_HI;
          end else begin
            st_next.illegal = 1'b1;
          end
        end
      end
      ST_FETCH2: begin
        if (I_BUS_ACK) begin
          st_next.state = ST_FETCH1;
          if (dec_out_inc) begin
            st_next.bus   = mem_rd(st_reg.regs.hl);
            st_next.state = ST_OI_RD;
          end else if (dec_pop_idx1 || dec_pop_idx2) begin
            st_next.dst   = dec_pop_idx1 ? DST_IDX1 : DST_IDX2;
            st_next.bus   = mem_rd(st_reg.regs.stack_pointer);
            st_next.state = ST_POP_LO;
          end else begin
            st_next.illegal = 1'b1;
          end
        end
      end
      ST_OI_RD: begin
        if (I_BUS_ACK) begin
          st_next.held           = fetched;
          st_next.regs.bc[15:8]  = count_dec;
          st_next.bus.io         = 1'b1;
          st_next.bus.wr         = 1'b1;
          st_next.bus.addr       = {count_dec, st_reg.regs.bc[7:0]};
          st_next.bus.wdata      = fetched;
          st_next.regs.af[FLAG_Z] = (count_dec == BYTE_ZERO);
          st_next.regs.af[FLAG_N] = 1'b1;
          st_next.state          = ST_OI_WR;
        end
      end
      ST_OI_WR: begin
        st_next.bus.wdata = st_reg.held;
        if (I_BUS_ACK) begin
          st_next.bus     = '0;
          st_next.regs.hl = st_reg.regs.hl + WORD_ONE;
          st_next.state   = ST_FETCH1;
        end
      end
      ST_POP_LO: begin
        if (I_BUS_ACK) begin
          st_next.lo                 = fetched;
          st_next.regs.stack_pointer = st_reg.regs.stack_pointer + WORD_ONE;
          st_next.bus                = mem_rd(st_reg.regs.stack_pointer + WORD_ONE);
          st_next.state              = ST_POP_HI;
        end
      end
      ST_POP_HI: begin
        if (I_BUS_ACK) begin
          st_next.bus                = '0;
          st_next.regs.stack_pointer = st_reg.regs.stack_pointer + WORD_ONE;
          st_next.state              = ST_FETCH1;
          // flags live in af low byte; only an af pop touches them
          if (st_reg.dst == DST_IDX1) begin
            st_next.regs.first_index_reg = {fetched, st_reg.lo};
          end else if (st_reg.dst == DST_IDX2) begin
            st_next.regs.second_index_reg = {fetched, st_reg.lo};
          end else if (st_reg.pair == PAIR_BC) begin
            st_next.regs.bc = {fetched, st_reg.lo};
          end else if (st_reg.pair == PAIR_DE) begin
            st_next.regs.de = {fetched, st_reg.lo};
          end else if (st_reg.pair == PAIR_HL) begin
            st_next.regs.hl = {fetched, st_reg.lo};
          end else begin
            st_next.regs.af = {fetched, st_reg.lo};
          end
        end
      end
      ST_PUSH_HI: begin
        st_next.bus.req   = 1'b1;
        st_next.bus.wr    = 1'b1;
        st_next.bus.io    = 1'b0;
        st_next.bus.addr  = st_reg.regs.stack_pointer;
        st_next.bus.wdata = push_value[15:8];
        if (st_reg.bus.req && I_BUS_ACK) begin
          st_next.regs.stack_pointer = st_reg.regs.stack_pointer - WORD_ONE;
          st_next.bus.addr  = st_reg.regs.stack_pointer - WORD_ONE;
          st_next.bus.wdata = push_value[7:0];
          st_next.state     = ST_PUSH_LO;
        end
      end
      ST_PUSH_LO: begin
        if (I_BUS_ACK) begin
          st_next.bus   = '0;
          st_next.state = ST_FETCH1;
        end
      end
      default: begin
        st_next.state = ST_FETCH1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg       <= '0;
      st_reg.state <= ST_FETCH1;
      st_reg.dst   <= DST_PAIR;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_BUS     = st_reg.bus;
  assign O_REGS    = st_reg.regs;
  assign O_IDLE    = (st_reg.state == ST_FETCH1);
  assign O_ILLEGAL = st_reg.illegal;

endmodule : sbo_core
`default_nettype wire

// *** sim/sbo_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbo_checker (
  input wire logic               I_MCLK,
  input wire logic               I_RST,
  input wire logic               I_BUS_ACK,
  input wire sbo_pkg::sbo_bus_t  O_BUS,
  input wire sbo_pkg::sbo_regs_t O_REGS,
  input wire logic               O_IDLE,
  input wire logic               O_ILLEGAL
);
  import sbo_pkg::*;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_bus_holds: assert property (O_BUS.req && !I_BUS_ACK |=> $stable(O_BUS))
    else $error("bus request changed before ack");
  a_idle_quiet: assert property (O_IDLE |-> !O_BUS.req)
    else $error("bus request while idle");
  a_illegal_quiet: assert property (O_ILLEGAL |-> !O_BUS.req)
    else $error("bus request after unknown opcode");
  a_io_addr: assert property (O_BUS.req && O_BUS.io |-> O_BUS.wr && O_BUS.addr == O_REGS.bc)
    else $error("io cycle address is not counter and port");
  a_io_flags: assert property (O_BUS.req && O_BUS.io |->
    O_REGS.af[FLAG_N] && (O_REGS.af[FLAG_Z] == (O_REGS.bc[15:8] == 8'h00)))
    else $error("zero or subtract flag wrong");
  a_read_first: assert property (O_BUS.req && $rose(O_BUS.io) |-> $past(O_BUS.req) && !$past(O_BUS.wr))
    else $error("io write not preceded by memory read");
  a_ptr_step: assert property (O_BUS.req && O_BUS.io && I_BUS_ACK |=>
    O_REGS.hl == $past(O_REGS.hl) + 16'h0001)
    else $error("memory pointer not incremented");
  a_pop_step: assert property ((O_BUS.req && !O_BUS.wr && !O_BUS.io && I_BUS_ACK) ##1
    (O_BUS.req && !O_BUS.wr) |-> O_BUS.addr == $past(O_BUS.addr) + 16'h0001)
    else $error("second pop read not at next address");
  a_push_step: assert property ((O_BUS.req && O_BUS.wr && !O_BUS.io && I_BUS_ACK) ##1
    (O_BUS.req && O_BUS.wr) |-> O_BUS.addr == $past(O_BUS.addr) - 16'h0001)
    else $error("second push write not at previous address");
  a_push_flags: assert property (O_BUS.req && O_BUS.wr && !O_BUS.io |->
    $stable(O_REGS.af[7:0]))
    else $error("flags changed during push");
  c_io_write: cover property (O_BUS.req && O_BUS.io && I_BUS_ACK);
  c_push: cover property (O_BUS.req && O_BUS.wr && !O_BUS.io && I_BUS_ACK);
  c_pop: cover property (O_BUS.req && !O_BUS.wr && I_BUS_ACK);
endmodule : sbo_checker
bind sbo_core sbo_checker u_chk (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_BUS_ACK(I_BUS_ACK),
  .O_BUS(O_BUS), .O_REGS(O_REGS), .O_IDLE(O_IDLE), .O_ILLEGAL(O_ILLEGAL));
`default_nettype wire

// *** sim/sbo_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbo_mem_model (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_slow,
  input  wire sbo_pkg::sbo_bus_t i_bus,
  output logic                   o_ack,
  output logic [7:0]             o_rdata,
  output logic [15:0]            o_io_addr,
  output logic [7:0]             o_io_data
);
  import sbo_pkg::*;
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;
  // released data line toggles so a stale byte is never mistaken for a read
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack    <= 1'b0;
      o_rdata  <= 8'h00;
      wait_cnt <= 2'h0;
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_bus.req && !o_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (!i_slow || wait_cnt == 2'h3) begin
          o_ack    <= 1'b1;
          wait_cnt <= 2'h0;
          if (!i_bus.wr) o_rdata <= mem[i_bus.addr];
          else if (i_bus.io) begin
            o_io_addr <= i_bus.addr;
            o_io_data <= i_bus.wdata;
          end else mem[i_bus.addr] <= i_bus.wdata;
        end
      end
    end
  end
endmodule : sbo_mem_model
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbo_pkg::*;
  logic clk, rst, tb_ack, load, slow, idle, illegal, mem_ack;
  logic [7:0] tb_op, mem_rdata, io_data;
  logic [15:0] io_addr, v;
  sbo_regs_t load_regs, regs, r;
  sbo_bus_t bus;
  int mismatches, checked;

  sbo_core DUT (.I_MCLK(clk), .I_RST(rst), .I_BUS_ACK(tb_ack | mem_ack),
    .I_BUS_RDATA(mem_ack ? mem_rdata : tb_op), .I_LOAD_REGS(load_regs), .I_LOAD(load),
    .O_BUS(bus), .O_REGS(regs), .O_IDLE(idle), .O_ILLEGAL(illegal));
  sbo_mem_model MEM (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_bus(bus), .o_ack(mem_ack),
    .o_rdata(mem_rdata), .o_io_addr(io_addr), .o_io_data(io_data));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic preset(input sbo_regs_t p);
    @(posedge clk);
    load_regs <= p;
    load      <= 1'b1;
    @(posedge clk);
    load      <= 1'b0;
  endtask : preset
  // opcode bytes on consecutive edges, then a bounded wait for idle
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    @(posedge clk);
    tb_ack <= 1'b1;
    tb_op  <= b0;
    if (two) begin
      @(posedge clk);
      tb_op <= b1;
    end
    @(posedge clk);
    tb_ack <= 1'b0;
    tb_op  <= ~b1;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      #1;
      if (idle === 1'b1) break;
    end
    chk({15'h0, idle}, 16'h0001);
  endtask : run
  function automatic logic [15:0] pick(input sbo_regs_t x, input int p);
    case (p)
      0: return x.bc;
      1: return x.de;
      2: return x.hl;
      default: return x.af;
    endcase
  endfunction : pick

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1; tb_ack = 1'b0; load = 1'b0; slow = 1'b0; tb_op = 8'h00;
    load_regs = '0; mismatches = 0; checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // counter reaching zero, then not, with a slow partner the second time
    for (int i = 0; i < 2; i++) begin
      r = '0;
      r.bc = {(i == 0) ? 8'h01 : 8'h05, 8'h7C};
      r.hl = 16'h12FF;
      r.af = 16'h00A5;
      MEM.mem[16'h12FF] = 8'h3C + 8'(i);
      slow <= 1'(i);
      preset(r);
      run(OP_PREFIX_ED, OP_OUT_INC, 1'b1);
      v = {r.bc[15:8] - 8'h01, 8'h7C};
      chk(io_addr, v);
      chk({8'h00, io_data}, {8'h00, 8'h3C + 8'(i)});
      chk(regs.hl, 16'h1300);
      chk(regs.bc, v);
      chk(regs.af, (i == 0) ? 16'h00E7 : 16'h00A7);
      chk({15'h0, illegal}, 16'h0000);
    end
    // pair pops across the top of memory, then both index pops from 4000
    for (int p = 0; p < 4; p++) begin
      r = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 16'hFFFF};
      MEM.mem[16'hFFFF] = 8'h10 + 8'(p);
      MEM.mem[16'h0000] = 8'h80 + 8'(p);
      preset(r);
      run(OP_POP_PAIR | 8'(p << 4), 8'h00, 1'b0);
      v = {8'h80 + 8'(p), 8'h10 + 8'(p)};
      chk(pick(regs, p), v);
      chk(regs.stack_pointer, 16'h0001);
      chk(regs.af, (p == 3) ? v : r.af);
    end
    for (int k = 0; k < 2; k++) begin
      r.stack_pointer = 16'h4000;
      MEM.mem[16'h4000] = 8'h5A + 8'(k);
      MEM.mem[16'h4001] = 8'hC3;
      preset(r);
      run(k ? OP_PREFIX_IDX2 : OP_PREFIX_IDX1, OP_POP_IDX, 1'b1);
      chk(k ? regs.second_index_reg : regs.first_index_reg, {8'hC3, 8'h5A + 8'(k)});
      chk(regs.stack_pointer, 16'h4002);
      chk(regs.af, r.af);
    end
    // pair pushes wrapping below zero
    for (int p = 0; p < 4; p++) begin
      r = '{16'h1122, 16'h3344, 16'h5566, 16'h7788, 16'h0000, 16'h0000, 16'h0001};
      preset(r);
      run(OP_PUSH_PAIR | 8'(p << 4), 8'h00, 1'b0);
      chk({8'h00, MEM.mem[16'h0000]}, pick(r, p) >> 8);
      chk({8'h00, MEM.mem[16'hFFFF]}, pick(r, p) & 16'h00FF);
      chk(regs.stack_pointer, 16'hFFFF);
      chk(regs.af, r.af);
    end
    run(OP_PREFIX_ED, 8'h00, 1'b1);
    chk({15'h0, illegal}, 16'h0001);
    end_sim();
  end
endmodule : tb
`default_nettype wire
